// file: cob_top.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "cob_regs.svh"
// Functional notes
// - Per-port bit picks 7-bit or 5-bit masking
// - Select one: 48 MHz clock, divide by eight
// - Select zero: 24 MHz clock, divide by four
// - One-way: lock set once after unlock
// - Otherwise lock sets and clears, each after unlock
module cob_top #(
    parameter int REMAP_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cob_pkg::cob_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire cob_pkg::cob_data_t pwdata,
    input wire logic [3:0] pstrb,
    output cob_pkg::cob_data_t prdata,
    output logic pready,
    output logic pslverr,
    output logic port1_mask_mode_sel,
    output logic port2_mask_mode_sel,
    output logic low_speed_clk_sel,
    output logic remap_lock_one_way,
    output logic pin_remap_lock,
    output logic [REMAP_W-1:0] remap_pin_registers,
    output logic ls_usb_clk
);
    import cob_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    cob_lock_if lk_if ();
    logic pready_q;
    logic pready_d;
    cob_data_t prdata_q;
    cob_data_t prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [3:0] cfg_q;
    logic [3:0] cfg_d;
    logic [3:0] done_q;
    logic [3:0] done_d;
    logic [REMAP_W-1:0] remap_q;
    logic [REMAP_W-1:0] remap_d;
    logic access;
    logic wr_en;
    logic cfg_wr;
    logic hit_unlock;
    logic hit_lock;
    logic hit_remap;
    logic hit_status;
    logic hit_cfg;
    logic mapped;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Register hits
    assign hit_unlock = (paddr == `COB_OFF_UNLOCK);
    assign hit_lock = (paddr == `COB_OFF_LOCK);
    assign hit_remap = (paddr == `COB_OFF_REMAP);
    assign hit_status = (paddr == `COB_OFF_STATUS);
    assign hit_cfg = (paddr == `COB_CFG5H_ADDR);
    assign mapped = hit_unlock | hit_lock | hit_remap | hit_status | hit_cfg;

    // Access phase before answer, and the completing write
    assign access = psel & penable & ~pready_q;
    assign wr_en = psel & penable & pready_q & pwrite & pstrb[0];
    assign cfg_wr = wr_en & hit_cfg;

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // One wait state, read data and error captured together
    always_comb begin
        pready_d = access;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (access) begin
            pslverr_d = ~mapped;
            prdata_d = '0;
            if (!pwrite) begin
                if (hit_lock) begin
                    prdata_d[`COB_BIT_LOCK] = lk_if.lock;
                end
                if (hit_remap) begin
                    prdata_d[REMAP_W-1:0] = remap_q;
                end
                if (hit_status) begin
                    prdata_d[`COB_ST_LOCK] = lk_if.lock;
                    prdata_d[`COB_ST_ARMED] = lk_if.armed;
                    prdata_d[`COB_ST_PROG] = &done_q;
                    prdata_d[`COB_ST_OPT_LO+3:`COB_ST_OPT_LO] = cfg_q;
                end
                if (hit_cfg) begin
                    prdata_d[7:0] = {`COB_CFG_UPPER, cfg_q};
                end
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ----------------------------------------
    // Option byte, write-once as a whole
    // ----------------------------------------
    // The first write programs all four bits from erased, then they hold
    for (genvar i = 0; i < 4; i++) begin : g_opt
        assign cfg_d[i] = (cfg_wr && !done_q[i]) ? pwdata[i] : cfg_q[i];
        assign done_d[i] = done_q[i] | cfg_wr;
    end

    // Option byte registers, erased at power-up
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `COB_CFG_ERASED;
            done_q <= 4'h0;
        end else begin
            cfg_q <= cfg_d;
            done_q <= done_d;
        end
    end

    // ----------------------------------------
    // Pin remap register
    // ----------------------------------------
    // Writes dropped while the lock is set
    always_comb begin
        remap_d = remap_q;
        if (wr_en && hit_remap && !lk_if.lock) begin
            remap_d = pwdata[REMAP_W-1:0];
        end
    end

    // Remap register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            remap_q <= `COB_REMAP_RST;
        end else begin
            remap_q <= remap_d;
        end
    end

    // ----------------------------------------
    // Lock control and clock divider
    // ----------------------------------------
    // Strobes toward the lock control
    assign lk_if.unlock_wr = wr_en & hit_unlock;
    assign lk_if.lock_wr = wr_en & hit_lock;
    assign lk_if.wdata = pwdata[7:0];
    assign lk_if.one_way = cfg_q[`COB_BIT_IOL1];

    cob_lock_ctl u_lock (
        .sys_clk (sys_clk),
        .rst_n (rst_n),
        .lk (lk_if.lk)
    );

    cob_clk_div u_div (
        .sys_clk (sys_clk),
        .rst_n (rst_n),
        .sel_48 (cfg_q[`COB_BIT_LS48]),
        .div_clk (ls_usb_clk)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Flop-driven outputs
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign port1_mask_mode_sel = cfg_q[`COB_BIT_MSK1];
    assign port2_mask_mode_sel = cfg_q[`COB_BIT_MSK2];
    assign low_speed_clk_sel = cfg_q[`COB_BIT_LS48];
    assign remap_lock_one_way = cfg_q[`COB_BIT_IOL1];
    assign pin_remap_lock = lk_if.lock;
    assign remap_pin_registers = remap_q;
endmodule // cob_top

// file: cob_regs.svh
`ifndef COB_REGS_SVH
`define COB_REGS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define COB_OFF_UNLOCK 24'h000000
`define COB_OFF_LOCK 24'h000004
`define COB_OFF_REMAP 24'h000008
`define COB_OFF_STATUS 24'h00000C
// Option byte index and its word address
`define COB_CFG5H_IDX 24'h300009
`define COB_CFG5H_ADDR (`COB_CFG5H_IDX << 2)

// ----------------------------------------
// Field positions
// ----------------------------------------
`define COB_BIT_MSK1 3
`define COB_BIT_MSK2 2
`define COB_BIT_LS48 1
`define COB_BIT_IOL1 0
`define COB_BIT_LOCK 0
`define COB_ST_LOCK 0
`define COB_ST_ARMED 1
`define COB_ST_PROG 2
`define COB_ST_OPT_LO 4

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define COB_CFG_ERASED 4'hF
`define COB_CFG_UPPER 4'hF
`define COB_REMAP_RST 8'h00
`define COB_KEY1 8'h55
`define COB_KEY2 8'hAA
`define COB_DIV48_HALF 3'h3
`define COB_DIV24_HALF 3'h1

`endif

// file: cob_pkg.sv
package cob_pkg;
    typedef logic [23:0] cob_addr_t;
    typedef logic [31:0] cob_data_t;
    typedef enum logic [1:0] {
        COB_LK_IDLE,
        COB_LK_KEY1,
        COB_LK_ARMED
    } cob_lock_st_e;
endpackage

// file: cob_lock_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link between bus logic and lock control
// ----------------------------------------
interface cob_lock_if;
    logic unlock_wr;
    logic lock_wr;
    logic [7:0] wdata;
    logic one_way;
    logic lock;
    logic armed;
    modport ctl (output unlock_wr, output lock_wr, output wdata, output one_way, input lock, input armed);
    modport lk (input unlock_wr, input lock_wr, input wdata, input one_way, output lock, output armed);
endinterface // cob_lock_if

// file: cob_lock_ctl.sv
`timescale 1ns/1ps
`include "cob_regs.svh"
module cob_lock_ctl (
    input wire logic sys_clk,
    input wire logic rst_n,
    cob_lock_if.lk lk
);
    import cob_pkg::*;

    cob_lock_st_e st_q;
    cob_lock_st_e st_d;
    logic lock_q;
    logic lock_d;

    // Key sequence and lock update
    always_comb begin
        st_d = st_q;
        lock_d = lock_q;
        if (lk.unlock_wr) begin
            if (lk.wdata == `COB_KEY1) begin
                st_d = COB_LK_KEY1;
            end else if (st_q == COB_LK_KEY1 && lk.wdata == `COB_KEY2) begin
                st_d = COB_LK_ARMED;
            end else begin
                st_d = COB_LK_IDLE;
            end
        end else if (lk.lock_wr) begin
            st_d = COB_LK_IDLE; // Any lock write spends the key
            case (st_q)
                COB_LK_ARMED: begin
                    if (lk.one_way) begin
                        lock_d = lock_q | lk.wdata[`COB_BIT_LOCK];
                    end else begin
                        lock_d = lk.wdata[`COB_BIT_LOCK];
                    end
                end
                default: begin
                    lock_d = lock_q;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= COB_LK_IDLE;
            lock_q <= 1'b0;
        end else begin
            st_q <= st_d;
            lock_q <= lock_d;
        end
    end

    assign lk.lock = lock_q;
    assign lk.armed = (st_q == COB_LK_ARMED);
endmodule // cob_lock_ctl

// file: cob_clk_div.sv
`timescale 1ns/1ps
`include "cob_regs.svh"
module cob_clk_div (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sel_48,
    output logic div_clk
);
    import cob_pkg::*;

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic clk_q;
    logic clk_d;
    logic [2:0] half;

    // Half period: 4 cycles for /8, 2 cycles for /4
    always_comb begin
        half = sel_48 ? `COB_DIV48_HALF : `COB_DIV24_HALF;
        cnt_d = cnt_q + 3'h1;
        clk_d = clk_q;
        if (cnt_q >= half) begin
            cnt_d = 3'h0;
            clk_d = ~clk_q;
        end
    end

    // Divider registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign div_clk = clk_q;
endmodule // cob_clk_div

// file: cob_chk_assertions.sv
`timescale 1ns/1ps
`include "cob_regs.svh"
module cob_chk #(
    parameter int REMAP_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cob_pkg::cob_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire cob_pkg::cob_data_t prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic port1_mask_mode_sel,
    input wire logic port2_mask_mode_sel,
    input wire logic low_speed_clk_sel,
    input wire logic remap_lock_one_way,
    input wire logic pin_remap_lock,
    input wire logic [REMAP_W-1:0] remap_pin_registers,
    input wire logic ls_usb_clk
);
    import cob_pkg::*;
    // ----
    // Clocking and helpers
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Option bits and completed accesses
    wire logic [3:0] opts = {port1_mask_mode_sel, port2_mask_mode_sel, low_speed_clk_sel, remap_lock_one_way};
    wire logic done = psel && penable && pready;
    wire logic rd_opt = done && !pwrite && paddr == `COB_CFG5H_ADDR;
    wire logic wr_lock = done && pwrite && paddr == `COB_OFF_LOCK;
    // ----
    // Properties
    // ----
    sequence s_hi8;
        ls_usb_clk[*4] ##1 !ls_usb_clk;
    endsequence
    sequence s_hi4;
        ls_usb_clk[*2] ##1 !ls_usb_clk;
    endsequence
    // Option write landing inside a high phase reshapes it
    sequence s_sel_moved8;
        ##[1:4] $changed(low_speed_clk_sel);
    endsequence
    sequence s_sel_moved4;
        ##[1:2] $changed(low_speed_clk_sel);
    endsequence
    property p_div8;
        $rose(ls_usb_clk) && low_speed_clk_sel |-> s_hi8 or s_sel_moved8;
    endproperty
    property p_div4;
        $rose(ls_usb_clk) && !low_speed_clk_sel |-> s_hi4 or s_sel_moved4;
    endproperty
    property p_one_way;
        remap_lock_one_way && pin_remap_lock |=> pin_remap_lock;
    endproperty
    property p_frozen;
        pin_remap_lock ##1 pin_remap_lock |-> $stable(remap_pin_registers);
    endproperty
    property p_lock_src;
        $changed(pin_remap_lock) |-> $past(wr_lock);
    endproperty
    property p_once;
        (~$past(opts) & opts) == 4'h0;
    endproperty
    property p_upper;
        rd_opt |-> prdata[7:4] == `COB_CFG_UPPER;
    endproperty
    property p_ready;
        psel && $rose(penable) |=> pready ##1 !pready;
    endproperty
    a_div8: assert property (p_div8) else $error("div8 high phase wrong");
    a_div4: assert property (p_div4) else $error("div4 high phase wrong");
    a_one_way: assert property (p_one_way) else $error("one-way lock cleared");
    a_frozen: assert property (p_frozen) else $error("remap changed while locked");
    a_lock_src: assert property (p_lock_src) else $error("lock moved without lock write");
    a_once: assert property (p_once) else $error("option bit returned to one");
    a_upper: assert property (p_upper) else $error("upper option bits not one");
    a_ready: assert property (p_ready) else $error("pready timing wrong");
endmodule // cob_chk

// file: testbench.sv
`timescale 1ns/1ps
`include "cob_regs.svh"
module testbench;
    import cob_pkg::*;
    // ----
    // Signals
    // ----
    localparam cob_addr_t ad_cfg = `COB_CFG5H_ADDR;
    localparam cob_addr_t ad_lock = `COB_OFF_LOCK;
    localparam cob_addr_t ad_map = `COB_OFF_REMAP;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    cob_addr_t paddr = 24'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    cob_data_t pwdata = 32'h0;
    cob_data_t prdata;
    cob_data_t rdata;
    logic pready, pslverr, serr, lock, lsclk;
    wire logic [3:0] opts;
    logic [7:0] remap;
    int error_cnt = 0;
    int total_checks = 0;
    // Clock 125 MHz
    always #4 sys_clk = ~sys_clk;
    cob_top #(.REMAP_W(8)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port1_mask_mode_sel(opts[3]), .port2_mask_mode_sel(opts[2]),
        .low_speed_clk_sel(opts[1]), .remap_lock_one_way(opts[0]), .pin_remap_lock(lock),
        .remap_pin_registers(remap), .ls_usb_clk(lsclk));
    // ----
    // Tasks
    // ----
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, result settled on return
    task automatic xfer(input cob_addr_t a, input logic w, input cob_data_t d);
        int n;
        @(posedge sys_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            end_sim();
        end
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic unlock();
        xfer(`COB_OFF_UNLOCK, 1'b1, 32'h55);
        xfer(`COB_OFF_UNLOCK, 1'b1, 32'hAA);
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
    endtask
    // Cycles from one rise of the slow clock to the next
    task automatic per(input int exp);
        int n, t;
        n = 0;
        t = 0;
        for (int i = 0; i < 4; i++) begin
            while (lsclk !== i[0] && n < 40) begin
                @(posedge sys_clk);
                #1;
                n++;
                if (i > 1) t++;
            end
        end
        if (n >= 40) begin
            error_cnt++;
            end_sim();
        end
        chk(t, exp);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        do_reset();
        chk(opts, 4'hF);
        xfer(ad_cfg, 1'b0, 32'h0);
        chk(rdata[7:0], 8'hFF);
        per(8);
        xfer(ad_cfg, 1'b1, 32'hF5);
        chk(opts, 4'h5);
        xfer(ad_cfg, 1'b1, 32'hFA);
        chk(opts, 4'h5);
        xfer(ad_cfg, 1'b0, 32'h0);
        chk(rdata[7:0], 8'hF5);
        per(4);
        $display("test options done");
        xfer(ad_map, 1'b1, 32'h3C);
        xfer(ad_lock, 1'b1, 32'h1);
        chk(lock, 1'b0);
        unlock();
        xfer(ad_lock, 1'b1, 32'h1);
        chk(lock, 1'b1);
        xfer(ad_map, 1'b1, 32'hC3);
        xfer(ad_map, 1'b0, 32'h0);
        chk(rdata[7:0], 8'h3C);
        unlock();
        xfer(ad_lock, 1'b1, 32'h0);
        chk(lock, 1'b1);
        $display("test one-way lock done");
        do_reset();
        xfer(ad_cfg, 1'b1, 32'hFA);
        chk(opts, 4'hA);
        per(8);
        unlock();
        xfer(`COB_OFF_STATUS, 1'b0, 32'h0);
        chk(rdata, 32'h000000A6);
        xfer(ad_lock, 1'b1, 32'h1);
        chk(lock, 1'b1);
        unlock();
        xfer(ad_lock, 1'b1, 32'h0);
        chk(lock, 1'b0);
        xfer(ad_map, 1'b1, 32'h5A);
        chk(remap, 8'h5A);
        $display("test free lock done");
        xfer(24'h000010, 1'b0, 32'h0);
        chk(serr, 1'b1);
        chk(rdata, 32'h0);
        $display("test unmapped done");
        end_sim();
    end
endmodule // testbench
bind cob_top cob_chk #(.REMAP_W(REMAP_W)) u_chk (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .port1_mask_mode_sel, .port2_mask_mode_sel, .low_speed_clk_sel,
    .remap_lock_one_way, .pin_remap_lock, .remap_pin_registers, .ls_usb_clk);
